// File: dv/mfh_dev_model.sv
// Field device model on the line UART octet side
`timescale 1ns/1ns
module mfh_dev_model
  import mfh_pkg::*;
(
  input  wire logic       clk_i,      // System clock
  input  wire logic       reset_i,    // Async reset
  input  wire logic       arm_i,      // New sequence, clears counts
  input  wire logic       slow_i,     // Stall every other cycle
  input  wire logic       mute_i,     // Never answer
  input  wire logic       bad_i,      // Corrupt reply checksum
  input  wire logic [6:0] txn_i,      // Master octets to await
  input  wire logic [6:0] rxn_i,      // Reply octets to send
  input  wire logic       tx_valid_i, // Octet offered
  input  wire logic [7:0] tx_byte_i,  // Offered octet
  output logic            tx_ready_o, // Octet taken
  output logic            rx_valid_o, // Reply octet strobe
  output logic [7:0]      rx_byte_o   // Reply octet
);
  logic [7:0] got [0:65];
  logic [6:0] nt;
  logic [6:0] nr;
  logic [3:0] gap;
  logic       ph;

  function automatic logic [5:0] fold(input logic [7:0] a);
    logic [7:0] c;
    c = a ^ MFH_CKS_SEED;
    return {c[7] ^ c[5] ^ c[3] ^ c[1], c[6] ^ c[4] ^ c[2] ^ c[0], c[7] ^ c[6], c[5] ^ c[4], c[3] ^ c[2], c[1] ^ c[0]};
  endfunction

  // Checksum bits count as zero while folding
  function automatic logic [7:0] rep(input logic [6:0] k);
    logic [7:0] x;
    x = 8'h40;
    for (int j = 0; j < 65; j++) if (j < rxn_i - 1) x ^= 8'h30 + j[7:0];
    return (k == rxn_i - 7'h01) ? {2'b01, fold(x) ^ {5'h00, bad_i}} : 8'h30 + {1'b0, k};
  endfunction

  assign tx_ready_o = !slow_i || ph;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i || arm_i) begin
      nt         <= 7'h00;
      nr         <= 7'h00;
      gap        <= 4'h0;
      ph         <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_byte_o  <= 8'h00;
    end else begin
      ph         <= !ph;
      rx_valid_o <= 1'b0;
      rx_byte_o  <= ~rx_byte_o;  // Last octet alternates with its inverse between strobes
      if (tx_valid_i && tx_ready_o) begin
        got[nt] <= tx_byte_i;
        nt      <= nt + 7'h01;
      end
      if (nt == txn_i && !mute_i && nr < rxn_i) begin
        gap <= gap + 4'h1;
        if (gap == 4'h3) begin
          rx_valid_o <= 1'b1;
          rx_byte_o  <= rep(nr);
          nr         <= nr + 7'h01;
        end
      end
    end
  end
endmodule

// File: dv/mfh_frame_handler_test.sv
// Register-level testbench for the frame handler
`timescale 1ns/1ns
module mfh_frame_handler_test;
  import mfh_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        wakeup = 1'b0;
  logic        arm = 1'b0;
  logic        slow = 1'b0;
  logic        mute = 1'b0;
  logic        bad = 1'b0;
  logic [6:0]  txn = 7'h00;
  logic [6:0]  rxn = 7'h01;
  logic        tx_valid;
  logic        tx_ready;
  logic        rx_valid;
  logic [7:0]  tx_byte;
  logic [7:0]  rx_byte;
  mfh_wb_req_t req = '0;
  mfh_wb_rsp_t rsp;
  logic [31:0] q;
  int          num_errors = 0;
  int          n_tests = 0;
  // Rows: type 0 wr, type 3 rd, type 1 ch0 wr, ch2 rd, type 2 wr, rd, type 1 ch0 rd, type 2 wr of full depth
  localparam logic [7:0] SEQ_CTL [8] = '{8'h21, 8'ha1, 8'h00, 8'hc4, 8'h65, 8'ha1, 8'h81, 8'h20};
  localparam logic [7:0] SEQ_TYP [8] = '{8'h15, 8'hca, 8'h40, 8'h40, 8'h80, 8'h80, 8'h40, 8'h80};
  localparam logic [5:0] M_LEN [8] = '{6'h05, 6'h09, 6'h02, 6'h07, 6'h01, 6'h01, 6'h07, 6'h20};
  localparam logic [5:0] R_LEN [8] = '{6'h07, 6'h09, 6'h09, 6'h02, 6'h01, 6'h01, 6'h07, 6'h20};
  localparam logic [5:0] D_LEN [8] = '{6'h03, 6'h09, 6'h09, 6'h07, 6'h00, 6'h01, 6'h02, 6'h01};
  localparam logic [6:0] TXN [8] = '{7'h03, 7'h02, 7'h04, 7'h02, 7'h04, 7'h03, 7'h02, 7'h42};
  localparam logic [6:0] RXN [8] = '{7'h01, 7'h02, 7'h01, 7'h03, 7'h01, 7'h03, 7'h03, 7'h02};
  // Flags: auto checksum, slow device, bad reply
  localparam logic [2:0] FLG [8] = '{3'h4, 3'h7, 3'h4, 3'h6, 3'h4, 3'h2, 3'h6, 3'h4};

  always #50 clk_i = ~clk_i;

  mfh_frame_handler i_dut (.clk_i(clk_i), .reset_i(reset_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .wakeup_run_i(wakeup), .tx_valid_o(tx_valid), .tx_byte_o(tx_byte), .tx_ready_i(tx_ready),
    .rx_valid_i(rx_valid), .rx_byte_i(rx_byte));
  mfh_dev_model i_dev (.clk_i(clk_i), .reset_i(reset_i), .arm_i(arm), .slow_i(slow), .mute_i(mute),
    .bad_i(bad), .txn_i(txn), .rxn_i(rxn), .tx_valid_i(tx_valid), .tx_byte_i(tx_byte),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte));

  task automatic complete_run();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle; the answer latency is not assumed
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, 4'hf, {a, 2'b00}, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (rsp.ack !== 1'b1 && k < 20);
    q = rsp.dat;
    req <= '0;
    if (k >= 20) begin
      num_errors++;
      complete_run();
    end
  endtask

  task automatic wst(input logic [1:0] s);
    int k;
    for (k = 0; k < 100; k++) begin
      wb(1'b0, MFH_A_STAT, 32'h0);
      if (q[1:0] === s) break;
    end
    if (k == 100) begin
      num_errors++;
      complete_run();
    end
  endtask

  task automatic arm_dev(input logic [6:0] t, input logic [6:0] r, input logic [2:0] f);
    @(posedge clk_i);
    txn  <= t;
    rxn  <= r;
    slow <= f[1];
    bad  <= f[0];
    arm  <= 1'b1;
    @(posedge clk_i);
    arm  <= 1'b0;
  endtask

  task automatic run(input int r);
    logic [7:0] b;
    logic [7:0] x;
    x = 8'h00;
    arm_dev(TXN[r], RXN[r], FLG[r]);
    wb(1'b1, MFH_A_CTRL, {29'h0, FLG[r][2], MFH_MODE_FH});
    wb(1'b1, MFH_A_MPD, {26'h0, M_LEN[r]});
    wb(1'b1, MFH_A_OD, {26'h0, R_LEN[r]});
    wb(1'b1, MFH_A_DPD, {26'h0, D_LEN[r]});
    for (int i = 0; i < TXN[r]; i++) begin
      b = (i == 0) ? SEQ_CTL[r] : (i == 1) ? SEQ_TYP[r] : 8'ha0 + i[7:0];
      x ^= (i == 1) ? (b & MFH_CKS_KEEP) : b;
      wb(1'b1, MFH_A_DATA, {24'h0, b});
    end
    wst(2'h3);
    chk({25'h0, i_dev.nt}, {25'h0, TXN[r]});
    chk({24'h0, i_dev.got[0]}, {24'h0, SEQ_CTL[r]});
    chk({24'h0, i_dev.got[1]}, {24'h0, FLG[r][2] ? {SEQ_TYP[r][7:6], i_dev.fold(x)} : SEQ_TYP[r]});
    wb(1'b1, MFH_A_DATA, 32'h5a);
    wb(1'b0, MFH_A_STAT, 32'h0);
    chk({25'h0, q[14:8]}, {25'h0, RXN[r]});
    chk({31'h0, q[2]}, {31'h0, FLG[r][0]});
    for (int i = 0; i < RXN[r]; i++) begin
      wb(1'b0, MFH_A_DATA, 32'h0);
      chk({24'h0, q[7:0]}, {24'h0, i_dev.rep(i[6:0])});
    end
    // Nothing pending now: the value read is thrown away
    wb(1'b0, MFH_A_DATA, 32'h0);
    wb(1'b1, MFH_A_STAT, 32'h4);
    wb(1'b0, MFH_A_STAT, 32'h0);
    chk({9'h0, q[22:0]}, 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    wb(1'b0, MFH_A_CTRL, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, MFH_A_STAT, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 6'h08, 32'hff);
    wb(1'b0, 6'h08, 32'h0);
    chk(q, 32'h0);
    // Mode 0 and a running wake-up both lock the buffer
    arm_dev(7'h01, 7'h01, 3'h0);
    wb(1'b1, MFH_A_DATA, 32'h21);
    wb(1'b1, MFH_A_CTRL, {30'h0, MFH_MODE_FH});
    wakeup <= 1'b1;
    wb(1'b1, MFH_A_DATA, 32'h21);
    wakeup <= 1'b0;
    wb(1'b0, MFH_A_STAT, 32'h0);
    chk({25'h0, q[14:8]}, 32'h0);
    chk({25'h0, i_dev.nt}, 32'h0);
    wb(1'b0, MFH_A_CTRL, 32'h0);
    chk(q, {30'h0, MFH_MODE_FH});
    // Reply never comes: skip, then reset, must free the buffer
    for (int k = 0; k < 2; k++) begin
      arm_dev(7'h02, 7'h02, 3'h0);
      mute <= 1'b1;
      wb(1'b1, MFH_A_DATA, 32'ha1);
      wb(1'b1, MFH_A_DATA, 32'hc0);
      wst(2'h2);
      wb(1'b1, MFH_A_CTRL, 32'h2 | (32'h8 << k));
      wb(1'b0, MFH_A_STAT, 32'h0);
      chk({16'h0, q[15:0]}, 32'h0);
      mute <= 1'b0;
    end
    for (int r = 0; r < 8; r++) run(r);
    complete_run();
  end
endmodule

// File: hdl/mfh_frame_handler.sv
// Message sequence frame handler with frame buffer and Wishbone registers
// Function
// - Master message: control octet, then type octet
// - Decode type, channel, direction from header
// - Type 0 moves one on-request octet
// - Type 0 ignores all three length registers
// - Type 1 on-request count from length register
// - Type 2 uses all three length registers
// - Type 3 handled like type 0
// - Subtype inferred from channel and lengths
// - Type 2 ignores channel field
// - Channel 0 process data, else on-request
// - Direction bit: 0 write, 1 read
// - 66-byte FIFO frame buffer shared by all channels
// - Write appends, read pops one byte
// - Inactive mode: writes dropped, reads return zero
// - One message; writes dropped until readout
// - Skip or reset forces buffer idle, empty
// - Data port takes one access every other cycle
// - Auto checksum over full buffered master message
// - Reply checksum checked, error flag raised
// - Control bit enables auto checksum
// - Mode field writable at any time
`timescale 1ns/1ns
module mfh_frame_handler
  import mfh_pkg::*;
(
  input  wire logic                 clk_i,         // 10 MHz system clock
  input  wire logic                 reset_i,       // Async reset, active high
  input  wire mfh_pkg::mfh_wb_req_t wb_req_i,      // Wishbone request
  output mfh_pkg::mfh_wb_rsp_t      wb_rsp_o,      // Wishbone answer
  input  wire logic                 wakeup_run_i,  // Wake-up procedure running
  output logic                      tx_valid_o,    // Octet to line UART valid
  output logic [7:0]                tx_byte_o,     // Octet to line UART
  input  wire logic                 tx_ready_i,    // Line UART took octet
  input  wire logic                 rx_valid_i,    // Octet from line UART
  input  wire logic [7:0]           rx_byte_i      // Received octet
);
  import mfh_pkg::*;

  logic [7:0]  mem_q [MFH_DEPTH];
  mfh_state_t  st_q;
  logic [6:0]  cnt_q;
  logic [6:0]  ptr_q;
  logic [7:0]  acc_q;
  logic [7:0]  mc_q;
  logic [7:0]  ckt_q;
  logic [1:0]  mode_q;
  logic        crc_q;
  logic [5:0]  mpd_q;
  logic [5:0]  od_q;
  logic [5:0]  dpd_q;
  logic        err_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        tx_valid_q;
  logic [7:0]  tx_byte_q;

  logic        acc_en;
  logic        wr_acc;
  logic [5:0]  widx;
  logic        fh_act;
  logic        clr_buf;
  logic [6:0]  tx_len;
  logic [6:0]  rx_len;
  logic        full;
  logic        wr_take;
  logic        rd_take;
  logic [7:0]  wr_byte;
  logic        rx_take;
  logic        rx_last;
  logic [7:0]  rx_acc_d;
  logic        tx_hs;
  logic        tx_last;
  logic        rd_last;
  logic        start_ok;

  // Lengths come from header octets plus length registers
  function automatic logic [13:0] mfh_lens(input logic [7:0] mc, input logic [7:0] type_check_octet,
                                           input logic [5:0] master_procdata_len, input logic [5:0] od,
                                           input logic [5:0] device_procdata_len);
    logic       rd;
    logic [1:0] ty;
    logic [1:0] ch;
    logic [6:0] t;
    logic [6:0] r;
    rd = mc[MFH_MC_RW];
    ty = type_check_octet[MFH_CKT_TY +: 2];
    ch = mc[MFH_MC_CH +: 2];
    t  = MFH_HDR_LEN;
    r  = MFH_CKS_LEN;
    case (ty)
      MFH_TYPE1: begin
        if (ch == MFH_CH_PD) begin
          if (rd) r = r + {1'b0, device_procdata_len};
          else t = t + {1'b0, master_procdata_len};
        end else if (rd) begin
          r = r + {1'b0, od};
        end else begin
          t = t + {1'b0, od};
        end
      end
      MFH_TYPE2: begin
        t = t + {1'b0, master_procdata_len};
        r = r + {1'b0, device_procdata_len};
        if (rd) r = r + {1'b0, od};
        else t = t + {1'b0, od};
      end
      default: begin
        if (rd) r = r + MFH_OD0_LEN;
        else t = t + MFH_OD0_LEN;
      end
    endcase
    return {t, r};
  endfunction

  assign acc_en  = wb_req_i.cyc && wb_req_i.stb && !ack_q;
  assign wr_acc  = acc_en && wb_req_i.we && wb_req_i.sel[0];
  assign widx    = wb_req_i.adr[7:2];
  // Wake-up owns the line; the buffer stays locked meanwhile
  assign fh_act  = (mode_q == MFH_MODE_FH) && !wakeup_run_i;
  assign clr_buf = wr_acc && widx == MFH_A_CTRL &&
                   (wb_req_i.dat[MFH_CTL_SKIP] || wb_req_i.dat[MFH_CTL_RST]);
  assign {tx_len, rx_len} = mfh_lens(mc_q, ckt_q, mpd_q, od_q, dpd_q);
  // Lengths past the buffer depth saturate here; such a message
  // never finishes sending and needs a skip or reset to recover
  assign full    = (cnt_q >= MFH_HDR_LEN && cnt_q >= tx_len) || cnt_q == MFH_DEPTH7;
  // One message only; host writes dropped once full or past send
  assign wr_take = wr_acc && widx == MFH_A_DATA && fh_act && !clr_buf &&
                   (st_q == MFH_ST_IDLE || st_q == MFH_ST_SEND) && !full;
  // A read with no reply pending pops nothing and returns zero
  assign rd_take = acc_en && !wb_req_i.we && widx == MFH_A_DATA && fh_act &&
                   st_q == MFH_ST_READ && !clr_buf;
  // Checksum bits of the type octet count as zero
  assign wr_byte = (cnt_q == MFH_OD0_LEN) ? (wb_req_i.dat[7:0] & MFH_CKS_KEEP)
                                          : wb_req_i.dat[7:0];
  // Octets outside the reply window are dropped, not buffered
  assign rx_take = rx_valid_i && st_q == MFH_ST_WAIT && !clr_buf;
  assign rx_last = rx_take && (cnt_q + MFH_CKS_LEN >= rx_len || cnt_q == MFH_DEPTH7 - MFH_CKS_LEN);
  assign rx_acc_d = acc_q ^ (rx_last ? (rx_byte_i & MFH_CKS_KEEP) : rx_byte_i);
  assign tx_hs   = tx_valid_q && tx_ready_i;
  assign tx_last = tx_hs && ptr_q >= MFH_OD0_LEN && ptr_q + MFH_OD0_LEN >= tx_len;
  assign rd_last = rd_take && ptr_q + MFH_OD0_LEN >= cnt_q;
  // Auto checksum needs the whole message before anything goes out
  assign start_ok = crc_q ? full : (cnt_q != 7'h00);

  // Frame buffer storage: host bytes, then the reply in place
  // No reset: only entries below the count are ever read back
  always_ff @(posedge clk_i) begin
    if (wr_take) begin
      mem_q[cnt_q] <= wb_req_i.dat[7:0];
    end else if (rx_take) begin
      mem_q[cnt_q] <= rx_byte_i;
    end
  end

  // Header octets kept aside, the reply overwrites the buffer
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mc_q  <= 8'h00;
      ckt_q <= 8'h00;
    end else if (wr_take && cnt_q == 7'h00) begin
      mc_q <= wb_req_i.dat[7:0];
    end else if (wr_take && cnt_q == MFH_OD0_LEN) begin
      ckt_q <= wb_req_i.dat[7:0];
    end
  end

  // Sequence state, counters and checksum accumulator
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q  <= MFH_ST_IDLE;
      cnt_q <= 7'h00;
      ptr_q <= 7'h00;
      acc_q <= 8'h00;
    end else if (clr_buf) begin
      st_q  <= MFH_ST_IDLE;
      cnt_q <= 7'h00;
      ptr_q <= 7'h00;
      acc_q <= 8'h00;
    end else begin
      if (wr_take) begin
        cnt_q <= cnt_q + 7'h01;
        acc_q <= acc_q ^ wr_byte;
      end
      case (st_q)
        MFH_ST_IDLE: begin
          if (fh_act && start_ok) st_q <= MFH_ST_SEND;
        end
        MFH_ST_SEND: begin
          if (tx_hs) ptr_q <= ptr_q + 7'h01;
          if (tx_last) begin
            st_q  <= MFH_ST_WAIT;
            cnt_q <= 7'h00;
            ptr_q <= 7'h00;
            acc_q <= 8'h00;
          end
        end
        MFH_ST_WAIT: begin
          if (rx_take) begin
            cnt_q <= cnt_q + 7'h01;
            acc_q <= rx_acc_d;
          end
          if (rx_last) st_q <= MFH_ST_READ;
        end
        MFH_ST_READ: begin
          if (rd_take) ptr_q <= ptr_q + 7'h01;
          if (rd_last) begin
            st_q  <= MFH_ST_IDLE;
            cnt_q <= 7'h00;
            ptr_q <= 7'h00;
            acc_q <= 8'h00;
          end
        end
        default: st_q <= MFH_ST_IDLE;
      endcase
    end
  end

  // Line transmit octet; checksum replaces the type octet low bits
  // One idle cycle between octets costs nothing against the line rate
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_valid_q <= 1'b0;
      tx_byte_q  <= 8'h00;
    end else if (clr_buf || tx_hs) begin
      tx_valid_q <= 1'b0;
    end else if (st_q == MFH_ST_SEND && !tx_valid_q && ptr_q < cnt_q) begin
      tx_valid_q <= 1'b1;
      if (crc_q && ptr_q == MFH_OD0_LEN) begin
        tx_byte_q <= {mem_q[ptr_q][7:6], mfh_cks6(acc_q)};
      end else begin
        tx_byte_q <= mem_q[ptr_q];
      end
    end
  end

  // Reply checksum error flag, new error wins over a clear
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      err_q <= 1'b0;
    end else if (rx_last && mfh_cks6(rx_acc_d) != rx_byte_i[5:0]) begin
      err_q <= 1'b1;
    end else if (wr_acc && widx == MFH_A_STAT && wb_req_i.dat[MFH_ST_ERR]) begin
      err_q <= 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q <= MFH_CTL_RV[1:0];
      crc_q  <= MFH_CTL_RV[2];
      mpd_q  <= 6'h00;
      od_q   <= 6'h00;
      dpd_q  <= 6'h00;
    end else if (wr_acc) begin
      case (widx)
        MFH_A_CTRL: begin
          mode_q <= wb_req_i.dat[MFH_CTL_MODE +: 2];
          crc_q  <= wb_req_i.dat[MFH_CTL_CRC];
        end
        MFH_A_MPD: mpd_q <= wb_req_i.dat[5:0];
        MFH_A_OD:  od_q  <= wb_req_i.dat[5:0];
        MFH_A_DPD: dpd_q <= wb_req_i.dat[5:0];
        default: ;
      endcase
    end
  end

  // Bus answer one cycle after the request; the next access waits one more cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= acc_en;
      if (acc_en && !wb_req_i.we) begin
        case (widx)
          MFH_A_CTRL: dat_q <= {27'h0, 2'h0, crc_q, mode_q};
          MFH_A_MPD:  dat_q <= {26'h0, mpd_q};
          MFH_A_OD:   dat_q <= {26'h0, od_q};
          MFH_A_DPD:  dat_q <= {26'h0, dpd_q};
          MFH_A_DATA: dat_q <= rd_take ? {24'h0, mem_q[ptr_q]} : 32'h0000_0000;
          MFH_A_STAT: dat_q <= {9'h0, ptr_q, 1'b0, cnt_q, 5'h0, err_q, st_q};
          default:    dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = dat_q;
  assign tx_valid_o   = tx_valid_q;
  assign tx_byte_o    = tx_byte_q;

  sequence s_rx_bad;
    rx_last && mfh_cks6(rx_acc_d) != rx_byte_i[5:0];
  endsequence

  sequence s_skip;
    clr_buf;
  endsequence

  sequence s_send_done;
    tx_last && !clr_buf;
  endsequence

  a_full_write_drop: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_acc && widx == MFH_A_DATA && (st_q == MFH_ST_READ || (full && st_q == MFH_ST_IDLE)) |=> $stable(cnt_q))
    else $error("write accepted into a full buffer");

  a_inactive_drop: assert property (@(posedge clk_i) disable iff (reset_i)
    !fh_act && st_q == MFH_ST_IDLE && !clr_buf |=> cnt_q == $past(cnt_q))
    else $error("buffer changed outside frame handler mode");

  a_skip_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    s_skip |=> st_q == MFH_ST_IDLE && cnt_q == 7'h00 && !tx_valid_q)
    else $error("skip did not empty the buffer");

  a_type0_lens: assert property (@(posedge clk_i) disable iff (reset_i)
    ckt_q[7] == ckt_q[6] |-> tx_len == (mc_q[7] ? 7'h02 : 7'h03) && rx_len == (mc_q[7] ? 7'h02 : 7'h01))
    else $error("type 0 lengths wrong");

  a_type2_lens: assert property (@(posedge clk_i) disable iff (reset_i)
    ckt_q[7:6] == MFH_TYPE2 |-> tx_len == 7'(7'h02 + mpd_q + (mc_q[7] ? 6'h00 : od_q)) &&
                               rx_len == 7'(7'h01 + dpd_q + (mc_q[7] ? od_q : 6'h00)))
    else $error("type 2 lengths wrong");

  a_tx_checksum: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(tx_valid_q) && crc_q && ptr_q == 7'h01 |-> tx_byte_q[5:0] == mfh_cks6(acc_q))
    else $error("sent checksum not computed");

  a_rx_check: assert property (@(posedge clk_i) disable iff (reset_i)
    s_rx_bad ##1 1'b1 |-> err_q && st_q == MFH_ST_READ)
    else $error("reply checksum error not flagged");

  a_pop_read: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_take && !rd_last |=> ptr_q == 7'($past(ptr_q) + 7'h01))
    else $error("read did not pop one byte");

  a_ack_one: assert property (@(posedge clk_i) disable iff (reset_i)
    acc_en |=> ack_q ##1 !ack_q)
    else $error("bus answer not one cycle");

  a_type1_lens: assert property (@(posedge clk_i) disable iff (reset_i)
    ckt_q[7:6] == MFH_TYPE1 |->
      tx_len == 7'(7'h02 + (mc_q[7] ? 6'h00 : (mc_q[6:5] == MFH_CH_PD ? mpd_q : od_q))) &&
      rx_len == 7'(7'h01 + (mc_q[7] ? (mc_q[6:5] == MFH_CH_PD ? dpd_q : od_q) : 6'h00)))
    else $error("type 1 lengths wrong");

  a_first_ctrl: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(tx_valid_q) && ptr_q == 7'h00 |-> tx_byte_q == mc_q)
    else $error("first sent octet is not the control octet");

  a_send_wait: assert property (@(posedge clk_i) disable iff (reset_i)
    s_send_done |=> st_q == MFH_ST_WAIT && cnt_q == 7'h00)
    else $error("no wait for reply after master message");

  a_read_done: assert property (@(posedge clk_i) disable iff (reset_i)
    rd_last && !clr_buf |=> st_q == MFH_ST_IDLE && cnt_q == 7'h00)
    else $error("buffer not free after full readout");

  a_crc_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    st_q == MFH_ST_IDLE && crc_q && !full |=> st_q == MFH_ST_IDLE)
    else $error("send started before full message");

  a_start_free: assert property (@(posedge clk_i) disable iff (reset_i)
    st_q == MFH_ST_IDLE && fh_act && !crc_q && cnt_q != 7'h00 && !clr_buf |=> st_q == MFH_ST_SEND)
    else $error("send did not start on first byte");
endmodule

// File: shared/mfh_pkg.sv
// Constants, types and checksum helper for the message sequence frame handler
package mfh_pkg;
  localparam int unsigned MFH_DEPTH  = 66;
  localparam logic [6:0]  MFH_DEPTH7 = 7'h42;

  // Register word indices (byte address = 4 * index)
  localparam logic [5:0] MFH_A_CTRL = 6'h00;
  localparam logic [5:0] MFH_A_MPD  = 6'h01;
  localparam logic [5:0] MFH_A_OD   = 6'h02;
  localparam logic [5:0] MFH_A_DPD  = 6'h03;
  localparam logic [5:0] MFH_A_DATA = 6'h04;
  localparam logic [5:0] MFH_A_STAT = 6'h05;

  // Control register fields
  localparam int unsigned MFH_CTL_MODE = 0;
  localparam int unsigned MFH_CTL_CRC  = 2;
  localparam int unsigned MFH_CTL_SKIP = 3;
  localparam int unsigned MFH_CTL_RST  = 4;
  localparam logic [1:0]  MFH_MODE_FH  = 2'h2;
  localparam logic [2:0]  MFH_CTL_RV   = 3'h0;

  // Status register fields
  localparam int unsigned MFH_ST_STATE = 0;
  localparam int unsigned MFH_ST_ERR   = 2;
  localparam int unsigned MFH_ST_CNT   = 8;
  localparam int unsigned MFH_ST_PTR   = 16;

  // Octet layouts
  localparam int unsigned MFH_MC_RW   = 7;
  localparam int unsigned MFH_MC_CH   = 5;
  localparam int unsigned MFH_CKT_TY  = 6;
  localparam logic [7:0]  MFH_CKS_KEEP = 8'hc0;
  localparam logic [7:0]  MFH_CKS_SEED = 8'h52;
  localparam logic [1:0]  MFH_TYPE1   = 2'h1;
  localparam logic [1:0]  MFH_TYPE2   = 2'h2;
  localparam logic [1:0]  MFH_CH_PD   = 2'h0;
  localparam logic [6:0]  MFH_HDR_LEN = 7'h02;
  localparam logic [6:0]  MFH_CKS_LEN = 7'h01;
  localparam logic [6:0]  MFH_OD0_LEN = 7'h01;

  typedef enum logic [1:0] {
    MFH_ST_IDLE = 2'b00,
    MFH_ST_SEND = 2'b01,
    MFH_ST_WAIT = 2'b10,
    MFH_ST_READ = 2'b11
  } mfh_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } mfh_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } mfh_wb_rsp_t;

  // Fold the seeded XOR of all octets into the 6-bit link checksum
  function automatic logic [5:0] mfh_cks6(input logic [7:0] acc);
    logic [7:0] c;
    c = acc ^ MFH_CKS_SEED;
    return {c[7] ^ c[5] ^ c[3] ^ c[1], c[6] ^ c[4] ^ c[2] ^ c[0],
            c[7] ^ c[6], c[5] ^ c[4], c[3] ^ c[2], c[1] ^ c[0]};
  endfunction
endpackage
